// ### src/prr_csum.sv
`timescale 1ns/1ps

module prr_csum (
  input  wire logic        clk,       // System clock
  input  wire logic        reset_n,   // Synchronous reset
  input  wire logic        start,     // First byte of a frame
  input  wire logic        add,       // Further byte of a frame
  input  wire logic        odd,       // Byte closes a 16-bit word
  input  wire logic [7:0]  data,      // Byte being sent
  output      logic [31:0] csum       // Two's complement of word sum
);

  logic [7:0]  hi_byte;
  logic [31:0] sum;

  // Complement of the 16-bit word sum, carries kept in 32 bits
  assign csum = 32'(~sum + 32'h0000_0001);

  // Pair bytes high first, then add each word
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hi_byte <= 8'h00;
      sum     <= 32'h0000_0000;
    end else if (start) begin
      hi_byte <= data;
      sum     <= 32'h0000_0000;
    end else if (add && !odd) begin
      hi_byte <= data;
    end else if (add) begin
      sum <= 32'(sum + {16'h0000, hi_byte, data});
    end
  end

endmodule

// ### src/prr_defines.svh
`ifndef PRR_DEFINES_SVH
`define PRR_DEFINES_SVH

// Command codes seen on the sideband
`define PRR_OP_GET_PARAMS   8'h17
`define PRR_OP_GET_STATS    8'h18
// Generic answer: command completed, no reason
`define PRR_RSP_COMPLETED   16'h0000
`define PRR_REASON_NONE     16'h0000

// Filter counts as reported by the capability answer
`define PRR_NUM_UNICAST     8'h04
`define PRR_NUM_MULTICAST   8'h02
`define PRR_NUM_MIXED       8'h02
`define PRR_NUM_MAC         8'h08
`define PRR_NUM_VLAN        8'h0F

// Response byte offsets
`define PRR_OFF_RESP        8'h10
`define PRR_OFF_MAC_CNT     8'h16
`define PRR_OFF_VLAN_FLAGS  8'h1A
`define PRR_OFF_LINK        8'h1C
`define PRR_OFF_BCAST       8'h20
`define PRR_OFF_CFG         8'h24
`define PRR_OFF_MAC         8'h30
`define PRR_OFF_PAD         8'h7E
`define PRR_OFF_CSUM        8'h80
`define PRR_OFF_LAST        8'h83

// Register word addresses
`define PRR_REG_LINK        8'h00
`define PRR_REG_BCAST       8'h01
`define PRR_REG_CFG         8'h02
`define PRR_REG_MODE        8'h03
`define PRR_REG_NOTICE      8'h04
`define PRR_REG_MAC_EN      8'h05
`define PRR_REG_VLAN_EN     8'h06
`define PRR_REG_STATUS      8'h07
`define PRR_REG_MAC_BASE    8'h10
`define PRR_REG_VLAN_BASE   8'h20

// Reset value of every configuration field
`define PRR_CFG_RESET       32'h0000_0000

`endif

// ### src/prr_pkg.sv
package prr_pkg;

  // Current settings as last written by the management side
  typedef struct packed {
    logic [31:0]       link;
    logic [31:0]       bcast;
    logic [3:0]        flags;
    logic [7:0]        vlan_mode;
    logic [7:0]        flow_en;
    logic [31:0]       notice;
    logic [7:0]        mac_en;
    logic [14:0]       vlan_en;
    logic [7:0][47:0]  mac;
    logic [14:0][15:0] vlan;
  } prr_cfg_t;

  // Decoded command from the packet front end
  typedef struct packed {
    logic         valid;
    logic         ok;
    logic [7:0]   code;
    logic [127:0] hdr;
  } prr_cmd_t;

  // Response byte stream
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } prr_tx_t;

  typedef enum logic [0:0] {
    PRR_IDLE,
    PRR_SEND
  } prr_state_t;

endpackage

// ### src/prr_regs.sv
`timescale 1ns/1ps
`include "prr_defines.svh"

module prr_regs
  import prr_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        reset_n,   // Synchronous reset
  input  wire logic [7:0]  addr,      // Word address
  input  wire logic [31:0] wdata,     // Write data
  input  wire logic        wr,        // Write strobe
  input  wire logic        rd,        // Read strobe
  input  wire logic [31:0] status,    // Live block state
  output      logic [31:0] rdata,     // Read data, next cycle
  output      prr_cfg_t    cfg        // Current settings
);

  logic [31:0] rd_mux;
  logic [3:0]  mac_sel;
  logic [3:0]  vlan_sel;
  logic        mac_hit;
  logic        vlan_hit;

  // Array windows: two words per address, one per tag
  assign mac_sel  = 4'(addr - `PRR_REG_MAC_BASE);
  assign vlan_sel = 4'(addr - `PRR_REG_VLAN_BASE);
  assign mac_hit  = (addr >= `PRR_REG_MAC_BASE) &&
                    (addr < `PRR_REG_MAC_BASE + 8'h10);
  assign vlan_hit = (addr >= `PRR_REG_VLAN_BASE) &&
                    (addr < `PRR_REG_VLAN_BASE + `PRR_NUM_VLAN);

  // Read select; unmapped words read as zero
  assign rd_mux =
    (addr == `PRR_REG_LINK)    ? cfg.link :
    (addr == `PRR_REG_BCAST)   ? cfg.bcast :
    (addr == `PRR_REG_CFG)     ? {28'h000_0000, cfg.flags} :
    (addr == `PRR_REG_MODE)    ? {16'h0000, cfg.vlan_mode, cfg.flow_en} :
    (addr == `PRR_REG_NOTICE)  ? cfg.notice :
    (addr == `PRR_REG_MAC_EN)  ? {24'h00_0000, cfg.mac_en} :
    (addr == `PRR_REG_VLAN_EN) ? {17'h0_0000, cfg.vlan_en} :
    (addr == `PRR_REG_STATUS)  ? status :
    (mac_hit && !mac_sel[0])   ? {16'h0000, cfg.mac[mac_sel[3:1]][47:32]} :
    mac_hit                    ? cfg.mac[mac_sel[3:1]][31:0] :
    vlan_hit                   ? {16'h0000, cfg.vlan[vlan_sel]} :
                                 32'h0000_0000;

  // Settings store; reserved flag bits are simply not kept
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg   <= '0;
      rdata <= `PRR_CFG_RESET;
    end else begin
      rdata <= rd ? rd_mux : 32'h0000_0000;
      if (wr) begin
        if (addr == `PRR_REG_LINK)    cfg.link      <= wdata;
        if (addr == `PRR_REG_BCAST)   cfg.bcast     <= wdata;
        if (addr == `PRR_REG_CFG)     cfg.flags     <= wdata[3:0];
        if (addr == `PRR_REG_MODE)    cfg.vlan_mode <= wdata[15:8];
        if (addr == `PRR_REG_MODE)    cfg.flow_en   <= wdata[7:0];
        if (addr == `PRR_REG_NOTICE)  cfg.notice    <= wdata;
        if (addr == `PRR_REG_MAC_EN)  cfg.mac_en    <= wdata[7:0];
        if (addr == `PRR_REG_VLAN_EN) cfg.vlan_en   <= wdata[14:0];
        if (mac_hit && !mac_sel[0])
          cfg.mac[mac_sel[3:1]][47:32] <= wdata[15:0];
        if (mac_hit && mac_sel[0])
          cfg.mac[mac_sel[3:1]][31:0] <= wdata;
        if (vlan_hit)
          cfg.vlan[vlan_sel] <= wdata[15:0];
      end
    end
  end

endmodule

// ### src/prr_top.sv
// Summary of operation
// (RULE1) Good read-back command always accepted and answered with a response; here one arriving while a response is sent is dropped and counted.
// (RULE2) Fields carry last written values; unsupported ones read as zero.
// (RULE3) Reason field holds only generic codes, here always none.
// (RULE4) Length follows filter counts; addresses packed with no gaps.
// (RULE5) Addresses ordered unicast, then multicast, then mixed entries.
// (RULE6) Bytes 0..15 header; 16..19 response code then reason code.
// (RULE7) Link settings at bytes 28..31; broadcast filter at 32..35.
// (RULE8) Config flags at 36..39; flow control and VLAN mode at 40..43.
// (RULE9) Addresses from byte 48, most significant byte first, contiguous.
// (RULE10) Sixteen-bit VLAN tags follow the addresses back to back.
// (RULE11) Optional padding after the last field, then the checksum word.
// (RULE12) Count fields give the supported address and tag numbers.
// (RULE13) Broadcast field is the active setting, not a default.
// (RULE14) Up to eight six-byte addresses and fifteen tags returned.
// (RULE15) Controller trusts values only when their enable flag is set.
// (RULE16) Address flag bit n-1 gives enable state of address n.
// (RULE17) Tag flag bit n-1 gives enable state of tag n.
// (RULE18) Flag bit 0 broadcast filter, bit 3 multicast; higher bits zero.
// (RULE19) Flag bit 1 channel enabled, bit 2 network transmit enabled.
// (RULE20) Statistics command 0x18 raises a request for aggregated counts.
// (RULE21) Statistics command is header, checksum and padding only.
// (RULE22) Unicast, multicast, mixed counts total at most eight, one usable.
// (RULE23) Zero padding aligns checksum to a four-byte offset.
`timescale 1ns/1ps
`include "prr_defines.svh"

module prr_top
  import prr_pkg::*;
(
  input  wire logic        clk,        // 40 MHz system clock
  input  wire logic        reset_n,    // Synchronous reset
  input  wire logic [7:0]  reg_addr,   // Register word address
  input  wire logic [31:0] reg_wdata,  // Register write data
  input  wire logic        reg_wr,     // Register write strobe
  input  wire logic        reg_rd,     // Register read strobe
  output      logic [31:0] reg_rdata,  // Read data, cycle after strobe
  input  wire prr_cmd_t    cmd,        // Decoded command
  output      logic        cmd_ready,  // Command can be taken
  output      prr_tx_t     tx,         // Response byte stream
  input  wire logic        tx_ready,   // Consumer takes the byte
  output      logic        stat_req    // Statistics request pulse
);

  prr_state_t   state;
  prr_state_t   next_state;
  prr_cfg_t     cfg;
  prr_cfg_t     snap;
  logic [127:0] hdr_snap;
  logic [7:0]   tx_idx;
  logic [7:0]   next_idx;
  logic [7:0]   next_byte;
  logic [7:0]   first_byte;
  logic [7:0]   csum_byte;
  logic [7:0]   csum_in;
  logic [31:0]  csum;
  logic [31:0]  status;
  logic [15:0]  drop_cnt;
  logic [15:0]  resp_cnt;
  logic [1023:0] frame;
  logic         take_params;
  logic         take_stats;
  logic         cmd_drop;
  logic         advance;
  logic         done;
  logic         load_body;

  // Pick byte k of the frame image, byte 0 in the top bits
  function automatic logic [7:0] pick(input logic [1023:0] f,
                                      input logic [7:0]    k);
    pick = f[(127 - k) * 8 +: 8];
  endfunction

  // Settings store behind the plain register port
  prr_regs u_regs (
    .clk     (clk),
    .reset_n (reset_n),
    .addr    (reg_addr),
    .wdata   (reg_wdata),
    .wr      (reg_wr),
    .rd      (reg_rd),
    .status  (status),
    .rdata   (reg_rdata),
    .cfg     (cfg)
  );

  // Running checksum over every byte before the checksum word
  prr_csum u_csum (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (take_params),
    .add     (load_body),
    .odd     (next_idx[0]),
    .data    (csum_in),
    .csum    (csum)
  );

  // Status word: low 15 bits of dropped count, busy, then count of answers
  assign status = {drop_cnt[14:0], (state == PRR_SEND), resp_cnt};

  // Command acceptance; a bad checksum or id mismatch is ignored
  // (RULE1) accept good command
  assign cmd_ready   = (state == PRR_IDLE);
  assign take_params = cmd.valid && cmd.ok && cmd_ready &&
                       (cmd.code == `PRR_OP_GET_PARAMS);
  // (RULE20) statistics request decode
  assign take_stats  = cmd.valid && cmd.ok &&
                       (cmd.code == `PRR_OP_GET_STATS);
  assign cmd_drop    = cmd.valid && cmd.ok && !cmd_ready &&
                       (cmd.code == `PRR_OP_GET_PARAMS);

  // Response image taken from the snapshot so a frame never mixes
  // old and new settings when software writes mid-frame
  // (RULE6) header and codes
  // (RULE3) generic reason only
  // (RULE12) supported counts
  // (RULE7) link and broadcast words
  // (RULE13) active broadcast value
  // (RULE8) flags and mode words
  // (RULE18) flag bits, reserved zero
  // (RULE19) channel and transmit flags
  // (RULE9) addresses most significant first
  // (RULE10) tags packed after addresses
  // (RULE5) unicast, multicast, mixed order
  // (RULE14) eight addresses, fifteen tags
  // (RULE16) address enable flags
  // (RULE17) tag enable flags
  // (RULE23) zero pad to alignment
  assign frame = {
    hdr_snap,
    `PRR_RSP_COMPLETED, `PRR_REASON_NONE,
    16'h0000, `PRR_NUM_MAC, snap.mac_en,
    `PRR_NUM_VLAN, 8'h00, 1'b0, snap.vlan_en,
    snap.link,
    snap.bcast,
    28'h000_0000, snap.flags,
    snap.vlan_mode, 16'h0000, snap.flow_en,
    snap.notice,
    snap.mac[0], snap.mac[1], snap.mac[2], snap.mac[3],
    snap.mac[4], snap.mac[5], snap.mac[6], snap.mac[7],
    snap.vlan[0],  snap.vlan[1],  snap.vlan[2],  snap.vlan[3],
    snap.vlan[4],  snap.vlan[5],  snap.vlan[6],  snap.vlan[7],
    snap.vlan[8],  snap.vlan[9],  snap.vlan[10], snap.vlan[11],
    snap.vlan[12], snap.vlan[13], snap.vlan[14],
    16'h0000
  };

  // First byte comes straight from the incoming header
  assign first_byte = cmd.hdr[127:120];

  // Checksum opens on the header byte; the index is stale at acceptance
  assign csum_in = take_params ? first_byte : next_byte;

  // Byte stepping; body bytes feed the checksum as they are loaded
  // (RULE11) checksum after padding
  assign advance   = tx.valid && tx_ready;
  assign done      = advance && (tx_idx == `PRR_OFF_LAST);
  assign next_idx  = 8'(tx_idx + 8'h01);
  assign csum_byte = csum[8 * (2'd3 - next_idx[1:0]) +: 8];
  assign next_byte = (next_idx < `PRR_OFF_CSUM) ? pick(frame, next_idx)
                                                : csum_byte;
  assign load_body = advance && (next_idx < `PRR_OFF_CSUM);

  // Sequencer: idle until a command, send until the last byte
  always_comb begin
    next_state = state;
    unique case (state)
      PRR_IDLE: begin
        if (take_params) begin
          next_state = PRR_SEND;
        end
      end
      PRR_SEND: begin
        if (done) begin
          next_state = PRR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= PRR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Snapshot of settings and header at acceptance
  // (RULE2) last written values
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      snap     <= '0;
      hdr_snap <= 128'h0;
    end else if (take_params) begin
      snap     <= cfg;
      hdr_snap <= cmd.hdr;
    end
  end

  // Output byte register; data is held while the consumer stalls
  // (RULE4) fixed-count frame length
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx     <= '0;
      tx_idx <= 8'h00;
    end else if (take_params) begin
      tx.valid <= 1'b1;
      tx.last  <= 1'b0;
      tx.data  <= first_byte;
      tx_idx   <= 8'h00;
    end else if (done) begin
      tx <= '0;
    end else if (advance) begin
      tx.data <= next_byte;
      tx.last <= (next_idx == `PRR_OFF_LAST);
      tx_idx  <= next_idx;
    end
  end

  // Statistics request goes to the counter block as one pulse
  // (RULE20) forward statistics request
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stat_req <= 1'b0;
    end else begin
      stat_req <= take_stats;
    end
  end

  // Activity counters; they wrap, software takes differences
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resp_cnt <= 16'h0000;
      drop_cnt <= 16'h0000;
    end else begin
      if (done) begin
        resp_cnt <= 16'(resp_cnt + 16'h0001);
      end
      if (cmd_drop) begin
        drop_cnt <= 16'(drop_cnt + 16'h0001);
      end
    end
  end

  // Checks on the response stream, the statistics pulse and the filter counts

  property p_accept;
    @(posedge clk) disable iff (!reset_n)
    take_params |=> tx.valid && (tx_idx == 8'h00) &&
                    (hdr_snap == $past(cmd.hdr));
  endproperty
  a_accept: assert property (p_accept) // RULE1
    else $error("good command not answered");

  property p_codes;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && (tx_idx >= `PRR_OFF_RESP) && (tx_idx < 8'h14)
      |-> tx.data == 8'h00;
  endproperty
  a_codes: assert property (p_codes) // RULE6
    else $error("response or reason code not zero");

  property p_count;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && (tx_idx == `PRR_OFF_MAC_CNT)
      |-> tx.data == 8'h08;
  endproperty
  a_count: assert property (p_count) // RULE12
    else $error("address count wrong");

  property p_vflags;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && (tx_idx == `PRR_OFF_VLAN_FLAGS)
      |-> tx.data == {1'b0, snap.vlan_en[14:8]};
  endproperty
  a_vflags: assert property (p_vflags) // RULE17
    else $error("tag flags wrong");

  property p_bcast;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && (tx_idx == `PRR_OFF_BCAST)
      |-> tx.data == snap.bcast[31:24];
  endproperty
  a_bcast: assert property (p_bcast) // RULE13
    else $error("broadcast field not current");

  property p_flags;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && (tx_idx == 8'h27)
      |-> tx.data == {4'h0, snap.flags};
  endproperty
  a_flags: assert property (p_flags) // RULE18
    else $error("configuration flags wrong");

  property p_mflags;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && (tx_idx == 8'h17)
      |-> tx.data == snap.mac_en;
  endproperty
  a_mflags: assert property (p_mflags) // RULE16
    else $error("address flags wrong");

  property p_hold;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && !tx_ready
      |=> tx.valid && $stable(tx.data);
  endproperty
  a_hold: assert property (p_hold) // RULE4
    else $error("byte lost while consumer stalls");

  property p_mac;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && (tx_idx == `PRR_OFF_MAC) && tx_ready
      |=> tx.data == snap.mac[0][39:32];
  endproperty
  a_mac: assert property (p_mac) // RULE9
    else $error("address byte order wrong");

  property p_pad;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && (tx_idx >= `PRR_OFF_PAD) && (tx_idx < `PRR_OFF_CSUM)
      |-> tx.data == 8'h00;
  endproperty
  a_pad: assert property (p_pad) // RULE23
    else $error("pad byte not zero");

  property p_last;
    @(posedge clk) disable iff (!reset_n)
    tx.valid && tx.last |-> tx_idx == `PRR_OFF_LAST;
  endproperty
  a_last: assert property (p_last) // RULE11
    else $error("frame ends at wrong byte");

  property p_stats;
    @(posedge clk) disable iff (!reset_n)
    take_stats |=> stat_req ##1 !stat_req || $past(take_stats);
  endproperty
  a_stats: assert property (p_stats) // RULE20
    else $error("statistics request missing");

  property p_filters;
    @(posedge clk) disable iff (!reset_n)
    (`PRR_NUM_UNICAST + `PRR_NUM_MULTICAST + `PRR_NUM_MIXED
      <= `PRR_NUM_MAC) &&
    (`PRR_NUM_UNICAST + `PRR_NUM_MIXED != 8'h00);
  endproperty
  a_filters: assert property (p_filters) // RULE22
    else $error("filter counts out of range");

endmodule

// ### tb/prr_mc_model.sv
`timescale 1ns/1ps

module prr_mc_model
  import prr_pkg::*;
(
  input  wire logic     clk,      // System clock
  input  wire logic     slow,     // Stall on alternate cycles
  output      prr_cmd_t cmd,      // Command to the channel
  input  wire prr_tx_t  tx,       // Response byte stream
  output      logic     tx_ready  // Takes the current byte
);
  logic [7:0] rx [0:131];  // Bytes received
  int         n_rx;        // Bytes taken, extras too
  int         last_at;     // Index that carried the end mark
  logic       hold;        // Stall phase

  initial begin
    cmd = '0;
    tx_ready = 1'b0;
    n_rx = 0;
    last_at = -1;
    hold = 1'b0;
  end

  // Byte sink; extra bytes still counted so overruns show up
  always @(posedge clk) begin
    if (tx.valid && tx_ready) begin
      if (n_rx < 132)
        rx[n_rx] = tx.data;
      if (tx.last)
        last_at = n_rx;
      n_rx = n_rx + 1;
    end
    hold = slow && !hold;
    tx_ready <= !hold;
  end

  // header-only requests, fields kept raw
  // Idle command lines show inverted values, not stale ones
  task automatic send(input logic [7:0] code, input logic ok,
                      input logic [127:0] hdr, input logic fresh);
    @(posedge clk);
    if (fresh) begin
      n_rx = 0;
      last_at = -1;
    end
    cmd <= '{valid: 1'b1, ok: ok, code: code, hdr: hdr};
    @(posedge clk);
    cmd <= '{valid: 1'b0, ok: ~ok, code: ~code, hdr: ~hdr};
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "prr_defines.svh"

module tb_top
  import prr_pkg::*;
;
  localparam logic [127:0] HDR = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
  logic        clk;        // 40 MHz clock
  logic        reset_n;    // Active-low reset
  logic [7:0]  reg_addr;   // Register address
  logic [31:0] reg_wdata;  // Register write data
  logic        reg_wr;     // Write strobe
  logic        reg_rd;     // Read strobe
  logic [31:0] reg_rdata;  // Read data
  prr_cmd_t    cmd;        // Command from controller
  logic        cmd_ready;  // Idle indication
  prr_tx_t     tx;         // Response stream
  logic        tx_ready;   // Consumer ready
  logic        stat_req;   // Statistics pulse
  logic        slow;       // Consumer stall mode
  logic [31:0] bcast_v;    // Broadcast setting in force
  logic [31:0] rv;         // Read value
  logic [7:0]  eb [0:131]; // Expected response bytes
  int          n_mismatch;
  int          tests_run;

  prr_top DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd(cmd), .cmd_ready(cmd_ready), .tx(tx),
    .tx_ready(tx_ready), .stat_req(stat_req));
  prr_mc_model MC (.clk(clk), .slow(slow), .cmd(cmd), .tx(tx),
    .tx_ready(tx_ready));

  // Free-running clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  function automatic logic [47:0] mac_val(input int n);
    return {8'h50 + 8'(n), 8'h40, 8'h30, 8'h20, 8'h10, 8'(n)};
  endfunction

  function automatic logic [15:0] vlan_val(input int n);
    return 16'hc300 + 16'(n);
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic put(input int o, input logic [31:0] v);
    for (int b = 0; b < 4; b++)
      eb[o + b] = v[31 - 8*b -: 8];
  endtask

  task automatic cfg_all();
    logic [47:0] m;
    reg_write(8'h00, 32'h1234_5678);
    reg_write(8'h01, bcast_v);
    reg_write(8'h02, 32'hffff_fffb);
    reg_write(8'h03, 32'h0000_0203);
    reg_write(8'h04, 32'ha5a5_0001);
    reg_write(8'h05, 32'h0000_00a5);
    reg_write(8'h06, 32'h0000_fa5a);
    for (int n = 0; n < 8; n++) begin
      m = mac_val(n);
      reg_write(8'h10 + 8'(2*n), {16'h0000, m[47:32]});
      reg_write(8'h11 + 8'(2*n), m[31:0]);
    end
    for (int n = 0; n < 15; n++)
      reg_write(8'h20 + 8'(n), {16'h0000, vlan_val(n)});
  endtask

  // Expected layout from the settings written above
  task automatic build();
    logic [31:0] s;
    logic [47:0] m;
    logic [15:0] v;
    for (int k = 0; k < 132; k++)
      eb[k] = 8'h00;
    for (int k = 0; k < 16; k++)
      eb[k] = HDR[127 - 8*k -: 8];
    put(20, 32'h0000_08a5);
    put(24, 32'h0f00_7a5a);
    put(28, 32'h1234_5678);
    put(32, bcast_v);
    put(36, 32'h0000_000b);
    put(40, 32'h0200_0003);
    put(44, 32'ha5a5_0001);
    for (int n = 0; n < 8; n++) begin
      m = mac_val(n);
      for (int b = 0; b < 6; b++)
        eb[48 + 6*n + b] = m[47 - 8*b -: 8];
    end
    for (int n = 0; n < 15; n++) begin
      v = vlan_val(n);
      eb[96 + 2*n] = v[15:8];
      eb[97 + 2*n] = v[7:0];
    end
    s = 32'h0000_0000;
    for (int k = 0; k < 128; k += 2)
      s = s + {16'h0000, eb[k], eb[k + 1]};
    put(128, -s);
  endtask

  task automatic wait_cmp();
    for (int i = 0; i < 600 && MC.n_rx < 132; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    check("byte count", 32'(MC.n_rx), 32'd132);
    check("end mark", 32'(MC.last_at), 32'd131);
    for (int k = 0; k < 132; k++)
      check($sformatf("byte %0d", k), 32'(MC.rx[k]), 32'(eb[k]));
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog, well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("[FAIL] watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    slow = 1'b0;
    bcast_v = 32'h0000_000f;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    // Settings and status clear after reset
    for (int a = 0; a < 8; a++) begin
      reg_read(8'(a), rv);
      check($sformatf("reset reg %0d", a), rv, 32'h0000_0000);
    end
    check("idle ready", 32'(cmd_ready), 32'h0000_0001);
    $display("test reset done");

    cfg_all();
    reg_read(8'h01, rv);
    check("bcast reg", rv, bcast_v);
    @(posedge clk);
    #1 check("rdata cleared", reg_rdata, 32'h0000_0000);
    reg_read(8'h11, rv);
    check("mac low reg", rv, 32'h3020_1000);
    reg_read(8'h0f, rv);
    check("unmapped reg", rv, 32'h0000_0000);
    $display("test registers done");

    // Bad checksum and foreign code give no answer
    MC.send(8'h17, 1'b0, HDR, 1'b1);
    #1 check("bad cmd ignored", 32'(tx.valid), 32'h0000_0000);
    MC.send(8'h19, 1'b1, HDR, 1'b1);
    #1 check("other code ignored", 32'(tx.valid), 32'h0000_0000);
    build();
    MC.send(8'h17, 1'b1, HDR, 1'b1);
    #1 check("busy", 32'(cmd_ready), 32'h0000_0000);
    wait_cmp();
    $display("test fast response done");

    // Changed filter, stalled consumer, drop and stats while busy
    bcast_v = 32'h0000_0005;
    reg_write(8'h01, bcast_v);
    build();
    slow <= 1'b1;
    MC.send(8'h17, 1'b1, HDR, 1'b1);
    MC.send(8'h17, 1'b1, ~HDR, 1'b0);
    MC.send(8'h18, 1'b1, HDR, 1'b0);
    #1 check("stats busy", 32'(stat_req), 32'h0000_0001);
    wait_cmp();
    slow <= 1'b0;
    reg_read(8'h07, rv);
    check("status", rv, {15'd1, 1'b0, 16'd2});
    $display("test slow response done");

    MC.send(8'h18, 1'b1, HDR, 1'b0);
    #1 check("stats pulse", 32'(stat_req), 32'h0000_0001);
    @(posedge clk);
    #1 check("stats end", 32'(stat_req), 32'h0000_0000);
    $display("test stats done");
    print_verdict();
  end
endmodule
